// [rtl/ioc_pkg.sv]
/*
 * Shared constants and types for the character transfer unit.
 * Assumes digits in core storage are six bits wide: C, F, 8, 4, 2, 1.
 */
package ioc_pkg;
    localparam int ADDR_W = 16;
    localparam int DIG_W  = 6;
    localparam int CNT_W  = 8;
    localparam int IN_W   = 10;
    localparam int OUT_W  = 11;

    localparam int BIT_C = 5;
    localparam int BIT_F = 4;

    localparam logic [ADDR_W-1:0] ADDR_ZERO = 16'h0000;
    localparam logic [ADDR_W-1:0] MOD1_END  = 16'h4E1F;
    localparam logic [ADDR_W-1:0] MOD2_END  = 16'h9C3F;
    localparam logic [ADDR_W-1:0] MOD3_END  = 16'hEA5F;

    localparam logic [3:0] NUM_ZERO   = 4'h0;
    localparam logic [3:0] NUM_RM     = 4'hA;
    localparam logic [3:0] NUM_RM_ALT = 4'hB;
    localparam logic [3:0] NUM_GM     = 4'hF;
    localparam logic [3:0] ZONE_NOPUNCH = 4'hF;

    localparam logic [7:0] UNIT_TYPE   = 8'h01;
    localparam logic [7:0] UNIT_TPUNCH = 8'h02;
    localparam logic [7:0] UNIT_CPUNCH = 8'h04;
    localparam logic [7:0] UNIT_CREAD  = 8'h05;
    localparam logic [7:0] UNIT_PRINT  = 8'h09;

    localparam logic [CNT_W-1:0] CARD_COLS = 8'h50;
    localparam logic [CNT_W-1:0] PRINT_POS = 8'hC5;
    localparam logic [CNT_W-1:0] CNT_ONE   = 8'h01;

    localparam int IN_EOL  = 9;
    localparam int IN_RM   = 8;
    localparam int IN_FLAG = 4;

    localparam int OUT_EOL   = 10;
    localparam int OUT_ALPHA = 9;
    localparam int OUT_FLAG  = 8;

    typedef enum logic [2:0] {
        read_numeric_instr,
        read_alpha_instr,
        write_numeric_instr,
        write_alpha_instr,
        dump_numeric_instr
    } ioc_op_type;

    // The check bit makes the count of 8-4-2-1-C odd, so zero is C alone.
    function automatic logic [DIG_W-1:0] ioc_digit(input logic f,
                                                   input logic [3:0] n);
        return {~^n, f, n};
    endfunction
endpackage

// [rtl/ioc_xfer_unit.sv]
/*
 * Character transfer unit for the read, write and dump instructions,
 * with the output FIFO that decouples it from the slow output units.
 * Assumes core storage answers a read one cycle after mem_rd and takes
 * a write in the cycle of mem_wr; mem_wflag low keeps the stored flag.
 */
// Operation
// - Read stores upward from the P address; alpha read starts at P-1.
// - Tape end-of-line stores zero then record mark; numeric read stores the mark only.
// - Card alpha read ends after eighty characters.
// - Alpha read stores zone then numeric digit.
// - Alpha read keeps existing flags untouched.
// - Lone record mark stores zero then C-8-2; numeric read stores C-8-2 only.
// - Numeric write stops at record mark.
// - Unreleased numeric write wraps to zero.
// - Numeric card write ends at column eighty.
// - Printer write ends at 197, pads blanks.
// - Numeric write sends digit with flag.
// - Typewriter alpha write suspends on leading mark.
// - Released alpha write emits no mark.
// - Alpha card write ends at column eighty.
// - Plotter takes digit magnitude, sign ignored.
// - Alpha write sends pairs, no flags.
// - Tape dump punches end-of-line after last.
// - Card dump fills the final card.
// - Printer dump loads exactly 197 characters.
// - Flagged zero dumps to card as flag only.
// - Eight-two codes act as record marks.
`timescale 1ns/10ps

module ioc_fifo
    import ioc_pkg::*;
#(
    parameter int W     = OUT_W,
    parameter int DEPTH = 8
) (
    input  wire logic         core_clk,
    input  wire logic         srst,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           rd;
        logic [PW-1:0]           wr;
        logic [PW:0]             cnt;
    } ioc_fifo_state_type;

    ioc_fifo_state_type fifo_ff;
    ioc_fifo_state_type nxt_fifo;

    logic push;
    logic pop;

    assign in_ready  = (fifo_ff.cnt != (PW+1)'(DEPTH));
    assign out_valid = (fifo_ff.cnt != '0);
    assign out_data  = fifo_ff.mem[fifo_ff.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        nxt_fifo = fifo_ff;
        if (push) begin
            nxt_fifo.mem[fifo_ff.wr] = in_data;
            nxt_fifo.wr = (fifo_ff.wr == PW'(DEPTH-1)) ? '0 : fifo_ff.wr + 1'b1;
        end
        if (pop) begin
            nxt_fifo.rd = (fifo_ff.rd == PW'(DEPTH-1)) ? '0 : fifo_ff.rd + 1'b1;
        end
        nxt_fifo.cnt = fifo_ff.cnt + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            fifo_ff <= '0;
        end else begin
            fifo_ff <= nxt_fifo;
        end
    end
endmodule

module ioc_xfer_unit
    import ioc_pkg::*;
#(
    parameter logic [ADDR_W-1:0] MEM_TOP       = 16'h4E1F,
    parameter int                FIFO_DEPTH    = 8,
    parameter bit                PLOTTER_ON_02 = 1'b0
) (
    input  wire logic              core_clk,
    input  wire logic              srst,
    input  wire logic              start,
    input  wire ioc_op_type        op,
    input  wire logic [ADDR_W-1:0] p_addr,
    input  wire logic [7:0]        unit_code,
    input  wire logic              release_key,
    input  wire logic              in_valid,
    input  wire logic [IN_W-1:0]   in_data,
    output logic                   in_ready,
    output logic                   mem_rd,
    output logic                   mem_wr,
    output logic [ADDR_W-1:0]      mem_addr,
    output logic [DIG_W-1:0]       mem_wdata,
    output logic                   mem_wflag,
    input  wire logic [DIG_W-1:0]  mem_rdata,
    output logic                   out_valid,
    input  wire logic              out_ready,
    output logic [OUT_W-1:0]       out_data,
    output logic                   busy,
    output logic                   done,
    output logic                   suspended
);
    typedef enum logic [3:0] {
        S_IDLE, S_RD_IN, S_WR_Z, S_WR_N, S_FETCH, S_RDREQ, S_RDCAP,
        S_EVAL, S_PUSH, S_PAD, S_EOL
    } ioc_st_type;

    typedef struct packed {
        ioc_st_type        st;
        ioc_op_type        op;
        logic [7:0]        unit;
        logic [ADDR_W-1:0] addr;
        logic [ADDR_W-1:0] mod_end;
        logic [CNT_W-1:0]  cnt;
        logic [CNT_W-1:0]  col;
        logic              half;
        logic              fin;
        logic              past_end;
        logic [3:0]        zone;
        logic [DIG_W-1:0]  dig;
        logic [OUT_W-1:0]  word;
        logic              mem_rd;
        logic              mem_wr;
        logic [ADDR_W-1:0] mem_addr;
        logic [DIG_W-1:0]  mem_wdata;
        logic              mem_wflag;
        logic              done;
        logic              suspended;
        logic              rel_s1;
        logic              rel_s2;
    } ioc_state_type;

    ioc_state_type st_ff;
    ioc_state_type nxt_st;

    logic             push_valid;
    logic [OUT_W-1:0] push_data;
    logic             push_ready;
    logic             is_mark;
    logic             is_gm;
    logic             plotter;
    logic [CNT_W-1:0] cnt_inc;
    logic [CNT_W-1:0] col_inc;

    function automatic logic [ADDR_W-1:0] adv(input logic [ADDR_W-1:0] a);
        return (a == MEM_TOP) ? ADDR_ZERO : a + 1'b1;
    endfunction

    // The sync chain keeps the console key's first flop private.
    assign busy      = (st_ff.st != S_IDLE);
    assign done      = st_ff.done;
    assign suspended = st_ff.suspended;
    assign mem_rd    = st_ff.mem_rd;
    assign mem_wr    = st_ff.mem_wr;
    assign mem_addr  = st_ff.mem_addr;
    assign mem_wdata = st_ff.mem_wdata;
    assign mem_wflag = st_ff.mem_wflag;
    assign in_ready  = (st_ff.st == S_RD_IN) && !st_ff.rel_s2;
    assign plotter   = PLOTTER_ON_02 && (st_ff.unit == UNIT_TPUNCH);
    assign is_mark   = (st_ff.dig[3:0] == NUM_RM) ||
                       (st_ff.dig[3:0] == NUM_RM_ALT);
    assign is_gm     = (st_ff.dig[3:0] == NUM_GM);
    assign cnt_inc   = st_ff.cnt + CNT_ONE;
    assign col_inc   = (st_ff.col == CARD_COLS - CNT_ONE) ? '0
                                                         : st_ff.col + CNT_ONE;
    assign push_valid = (st_ff.st == S_PUSH) || (st_ff.st == S_PAD) ||
                        (st_ff.st == S_EOL);

    always_comb begin
        push_data = st_ff.word;
        if (st_ff.st == S_PAD) begin
            push_data = '0;
            push_data[OUT_ALPHA] = 1'b1;
        end else if (st_ff.st == S_EOL) begin
            push_data = '0;
            push_data[OUT_EOL] = 1'b1;
        end
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rel_s1 = release_key;
        nxt_st.rel_s2 = st_ff.rel_s1;
        nxt_st.mem_rd = 1'b0;
        nxt_st.mem_wr = 1'b0;
        nxt_st.done = 1'b0;
        unique case (st_ff.st)
            S_IDLE: begin
                if (start) begin
                    nxt_st.op = op;
                    nxt_st.unit = unit_code;
                    nxt_st.addr = p_addr;
                    // An odd P names the numeric digit, so a pair starts below.
                    if (op inside {read_alpha_instr, write_alpha_instr}) begin
                        nxt_st.addr = p_addr - 1'b1;
                    end
                    nxt_st.cnt = '0;
                    nxt_st.col = '0;
                    nxt_st.half = 1'b0;
                    nxt_st.fin = 1'b0;
                    nxt_st.past_end = 1'b0;
                    nxt_st.suspended = 1'b0;
                    nxt_st.mod_end = (p_addr <= MOD1_END) ? MOD1_END :
                                     (p_addr <= MOD2_END) ? MOD2_END :
                                     MOD3_END;
                    if (op == read_alpha_instr || op == read_numeric_instr) begin
                        nxt_st.st = S_RD_IN;
                    end else begin
                        nxt_st.st = S_FETCH;
                    end
                end
            end
            S_RD_IN: begin
                if (st_ff.rel_s2) begin
                    nxt_st.st = S_IDLE;
                    nxt_st.done = 1'b1;
                end else if (in_valid) begin
                    nxt_st.fin = in_data[IN_EOL];
                    nxt_st.zone = in_data[7:4];
                    nxt_st.dig = {1'b0, in_data[IN_FLAG], in_data[3:0]};
                    if (in_data[IN_EOL] || in_data[IN_RM]) begin
                        nxt_st.zone = NUM_ZERO;
                        nxt_st.dig = {2'b00, NUM_RM};
                    end
                    nxt_st.st = (st_ff.op == read_alpha_instr) ? S_WR_Z
                                                               : S_WR_N;
                end
            end
            S_WR_Z: begin
                nxt_st.mem_wr = 1'b1;
                nxt_st.mem_addr = st_ff.addr;
                nxt_st.mem_wdata = ioc_digit(1'b0, st_ff.zone);
                nxt_st.mem_wflag = 1'b0;
                nxt_st.addr = adv(st_ff.addr);
                nxt_st.st = S_WR_N;
            end
            S_WR_N: begin
                nxt_st.mem_wr = 1'b1;
                nxt_st.mem_addr = st_ff.addr;
                nxt_st.mem_wdata = ioc_digit(st_ff.dig[BIT_F],
                                             st_ff.dig[3:0]);
                nxt_st.mem_wflag = (st_ff.op == read_numeric_instr);
                nxt_st.addr = adv(st_ff.addr);
                nxt_st.cnt = cnt_inc;
                nxt_st.st = S_RD_IN;
                if (st_ff.fin || (st_ff.unit == UNIT_CREAD &&
                                  cnt_inc == CARD_COLS)) begin
                    nxt_st.st = S_IDLE;
                    nxt_st.done = 1'b1;
                end
            end
            S_FETCH: begin
                if (st_ff.rel_s2 && !st_ff.half) begin
                    nxt_st.st = S_IDLE;
                    nxt_st.done = 1'b1;
                end else begin
                    nxt_st.mem_rd = 1'b1;
                    nxt_st.mem_addr = st_ff.half ? adv(st_ff.addr)
                                                 : st_ff.addr;
                    nxt_st.st = S_RDREQ;
                end
            end
            S_RDREQ: begin
                nxt_st.st = S_RDCAP;
            end
            S_RDCAP: begin
                if (st_ff.op == write_alpha_instr && !st_ff.half) begin
                    nxt_st.zone = mem_rdata[3:0];
                    nxt_st.half = 1'b1;
                    nxt_st.st = S_FETCH;
                end else begin
                    nxt_st.dig = mem_rdata;
                    nxt_st.half = 1'b0;
                    nxt_st.st = S_EVAL;
                end
            end
            S_EVAL: begin
                nxt_st.word = '0;
                nxt_st.word[OUT_FLAG] = st_ff.dig[BIT_F];
                nxt_st.word[3:0] = st_ff.dig[3:0];
                nxt_st.st = S_PUSH;
                if (st_ff.op == write_alpha_instr) begin
                    nxt_st.word[OUT_FLAG] = 1'b0;
                    nxt_st.word[OUT_ALPHA] = !plotter;
                    nxt_st.word[7:4] = plotter ? NUM_ZERO : st_ff.zone;
                end
                if (st_ff.op == dump_numeric_instr &&
                    st_ff.unit == UNIT_CPUNCH && st_ff.dig[BIT_F] &&
                    st_ff.dig[3:0] == NUM_ZERO) begin
                    nxt_st.word[7:4] = ZONE_NOPUNCH;
                end
                if (st_ff.op != dump_numeric_instr && (is_mark || is_gm)) begin
                    nxt_st.done = 1'b1;
                    nxt_st.st = S_IDLE;
                    if (st_ff.unit == UNIT_PRINT) begin
                        nxt_st.done = 1'b0;
                        nxt_st.st = S_PAD;
                    end else if (st_ff.unit == UNIT_TPUNCH && !plotter &&
                                 is_mark) begin
                        nxt_st.done = 1'b0;
                        nxt_st.st = S_EOL;
                    end else if (st_ff.unit == UNIT_TYPE && is_mark &&
                                 st_ff.op == write_alpha_instr &&
                                 st_ff.cnt == '0) begin
                        nxt_st.suspended = 1'b1;
                    end
                end
            end
            S_PUSH: begin
                if (push_ready) begin
                    nxt_st.cnt = cnt_inc;
                    nxt_st.col = col_inc;
                    nxt_st.addr = adv(st_ff.addr);
                    if (st_ff.op == write_alpha_instr) begin
                        nxt_st.addr = adv(adv(st_ff.addr));
                    end
                    if (st_ff.addr == st_ff.mod_end ||
                        adv(st_ff.addr) == st_ff.mod_end) begin
                        nxt_st.past_end = (st_ff.op != write_alpha_instr) ||
                                          adv(st_ff.addr) == st_ff.mod_end;
                        if (st_ff.op == dump_numeric_instr) begin
                            nxt_st.past_end = (st_ff.addr == st_ff.mod_end);
                        end
                    end
                    nxt_st.st = S_FETCH;
                    if (st_ff.op == dump_numeric_instr) begin
                        if (st_ff.unit == UNIT_PRINT) begin
                            if (cnt_inc == PRINT_POS) begin
                                nxt_st.st = S_IDLE;
                                nxt_st.done = 1'b1;
                            end
                        end else if (st_ff.unit == UNIT_CPUNCH) begin
                            if ((st_ff.past_end ||
                                 st_ff.addr == st_ff.mod_end) &&
                                col_inc == '0) begin
                                nxt_st.st = S_IDLE;
                                nxt_st.done = 1'b1;
                            end
                        end else if (st_ff.addr == st_ff.mod_end) begin
                            nxt_st.done = 1'b1;
                            nxt_st.st = S_IDLE;
                            if (st_ff.unit == UNIT_TPUNCH && !plotter) begin
                                nxt_st.done = 1'b0;
                                nxt_st.st = S_EOL;
                            end
                        end
                    end else if (st_ff.unit == UNIT_CPUNCH &&
                                 cnt_inc == CARD_COLS) begin
                        nxt_st.st = S_IDLE;
                        nxt_st.done = 1'b1;
                    end else if (st_ff.unit == UNIT_PRINT &&
                                 cnt_inc == PRINT_POS) begin
                        nxt_st.st = S_IDLE;
                        nxt_st.done = 1'b1;
                    end
                end
            end
            S_PAD: begin
                if (push_ready) begin
                    nxt_st.cnt = cnt_inc;
                    if (cnt_inc == PRINT_POS) begin
                        nxt_st.st = S_IDLE;
                        nxt_st.done = 1'b1;
                    end
                end
            end
            S_EOL: begin
                if (push_ready) begin
                    nxt_st.st = S_IDLE;
                    nxt_st.done = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Slow units stall the FIFO, which in turn holds the fetch loop.
    ioc_fifo #(
        .W     (OUT_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .srst      (srst),
        .in_valid  (push_valid),
        .in_data   (push_data),
        .in_ready  (push_ready),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_data)
    );

    flag_keep_a: assert property (@(posedge core_clk) disable iff (srst)
        mem_wr && st_ff.op == read_alpha_instr |-> !mem_wflag)
        else $error("alpha read overwrote a flag");

    lone_mark_a: assert property (@(posedge core_clk) disable iff (srst)
        st_ff.st == S_RD_IN && in_valid && in_ready && in_data[IN_RM] &&
        st_ff.op == read_alpha_instr
        |-> ##2 (mem_wr && mem_wdata == ioc_digit(1'b0, NUM_ZERO))
            ##1 (mem_wr && mem_wdata[3:0] == NUM_RM && mem_wdata[BIT_C]))
        else $error("lone record mark stored wrongly");

    store_kept_a: assert property (@(posedge core_clk) disable iff (srst)
        busy && st_ff.op inside {write_numeric_instr, write_alpha_instr,
                                 dump_numeric_instr} |-> !mem_wr)
        else $error("output instruction wrote storage");

    alpha_noflag_a: assert property (@(posedge core_clk) disable iff (srst)
        push_valid && push_ready && st_ff.op == write_alpha_instr
        |-> !push_data[OUT_FLAG])
        else $error("alpha write sent a flag");

    plot_mag_a: assert property (@(posedge core_clk) disable iff (srst)
        st_ff.st == S_PUSH && plotter && st_ff.op == write_alpha_instr
        |-> !push_data[OUT_ALPHA] && push_data[7:4] == NUM_ZERO)
        else $error("plotter word carries a zone");

    addr_wrap_a: assert property (@(posedge core_clk) disable iff (srst)
        st_ff.st == S_PUSH && push_ready && st_ff.addr == MEM_TOP &&
        st_ff.op != write_alpha_instr |=> st_ff.addr == ADDR_ZERO)
        else $error("address did not wrap");

    rel_end_a: assert property (@(posedge core_clk) disable iff (srst)
        st_ff.st == S_FETCH && st_ff.rel_s2 && !st_ff.half
        |=> !busy && done ##1 !done)
        else $error("release did not end transfer");

    print_len_a: assert property (@(posedge core_clk) disable iff (srst)
        done && st_ff.unit == UNIT_PRINT && !$past(st_ff.rel_s2) &&
        st_ff.op inside {write_numeric_instr, dump_numeric_instr}
        |-> st_ff.cnt == PRINT_POS)
        else $error("printer buffer not fully loaded");
endmodule

// [dv/ioc_unit_model.sv]
/*
 * Far side of the transfer unit: core storage and a slow output unit.
 * Assumes one clock; storage answers one cycle after a read strobe.
 */
`timescale 1ns/10ps
module ioc_unit_model
    import ioc_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              mem_rd,
    input  wire logic              mem_wr,
    input  wire logic [ADDR_W-1:0] mem_addr,
    input  wire logic [DIG_W-1:0]  mem_wdata,
    input  wire logic              mem_wflag,
    output logic      [DIG_W-1:0]  mem_rdata,
    input  wire logic              out_valid,
    input  wire logic [OUT_W-1:0]  out_data,
    output logic                   out_ready
);
    logic [DIG_W-1:0] mem [0:19999];
    logic [OUT_W-1:0] got [$];
    initial begin
        out_ready = 1'b0;
        mem_rdata = 6'h00;
        for (int i = 0; i < 20000; i++) mem[i] = 6'h20;
    end
    // The unit takes a word only every other cycle, still faster than the fetch loop pushes words.
    always @(posedge core_clk) begin
        if (out_valid && out_ready) got.push_back(out_data);
        out_ready <= ~out_ready;
        if (mem_wr) mem[mem_addr] <= {mem_wdata[5],
            mem_wflag ? mem_wdata[4] : mem[mem_addr][4], mem_wdata[3:0]};
        // Outside a read answer the data lines toggle rather than hold.
        mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
    end
endmodule

// [dv/tb_ioc_xfer_unit.sv]
/*
 * Self-checking bench for the transfer unit.
 * Assumes the storage and output unit model sits on the far side.
 */
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin \
    bad_count++; $display("CHECK FAILED %s exp %0h got %0h", nm, ex, gt); \
    end end
module tb_ioc_xfer_unit;
    import ioc_pkg::*;
    logic              core_clk, srst, start, release_key, in_valid;
    ioc_op_type        op;
    logic [ADDR_W-1:0] p_addr, mem_addr;
    logic [7:0]        unit_code;
    logic [IN_W-1:0]   in_data;
    logic [DIG_W-1:0]  mem_wdata, mem_rdata;
    logic [OUT_W-1:0]  out_data;
    logic              in_ready, mem_rd, mem_wr, mem_wflag, out_valid;
    logic              out_ready, busy, done, suspended;
    int                bad_count, cmp_count, cyc;

    ioc_xfer_unit ioc_xfer_unit_inst (.core_clk(core_clk), .srst(srst),
        .start(start), .op(op), .p_addr(p_addr), .unit_code(unit_code),
        .release_key(release_key), .in_valid(in_valid), .in_data(in_data),
        .in_ready(in_ready), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wflag(mem_wflag),
        .mem_rdata(mem_rdata), .out_valid(out_valid), .out_ready(out_ready),
        .out_data(out_data), .busy(busy), .done(done),
        .suspended(suspended));
    ioc_unit_model ioc_unit_model_inst (.core_clk(core_clk),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_wflag(mem_wflag),
        .mem_rdata(mem_rdata), .out_valid(out_valid),
        .out_data(out_data), .out_ready(out_ready));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("TB: %0d mismatches, %0d compares", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic run(ioc_op_type o, logic [15:0] p, logic [7:0] u);
        ioc_unit_model_inst.got.delete();
        @(posedge core_clk) #2;
        start = 1'b1; op = o; p_addr = p; unit_code = u;
        @(posedge core_clk) #2;
        start = 1'b0;
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            @(posedge core_clk) #1;
            n++;
        end while (done !== 1'b1 && n < 5000);
        `CHK("done", 1'b1, done)
        repeat (40) @(posedge core_clk);
    endtask
    task automatic send(logic [IN_W-1:0] d);
        @(posedge core_clk) #2;
        in_valid = 1'b1; in_data = d;
        while (in_ready !== 1'b1) @(posedge core_clk) #2;
        @(posedge core_clk) #2;
        in_valid = 1'b0;
    endtask

    task automatic t_read_tape();
        ioc_unit_model_inst.mem[100] = 6'h30;
        run(read_alpha_instr, 16'h0065, 8'h03);
        send(10'h041);
        send(10'h200);
        wait_done();
        `CHK("zone", 6'h14, ioc_unit_model_inst.mem[100])
        `CHK("num", 6'h01, ioc_unit_model_inst.mem[101])
        `CHK("eol zero", 6'h20, ioc_unit_model_inst.mem[102])
        `CHK("eol mark", 6'h2A, ioc_unit_model_inst.mem[103])
    endtask
    task automatic t_read_num();
        run(read_numeric_instr, 16'h0190, 8'h03);
        send(10'h017);
        send(10'h200);
        wait_done();
        `CHK("n digit", 6'h17, ioc_unit_model_inst.mem[400])
        `CHK("n mark", 6'h2A, ioc_unit_model_inst.mem[401])
    endtask
    task automatic t_lone_mark();
        run(read_alpha_instr, 16'h00C9, 8'h01);
        send(10'h100);
        @(posedge core_clk) #2 release_key = 1'b1;
        wait_done();
        #2 release_key = 1'b0;
        `CHK("rm zero", 6'h20, ioc_unit_model_inst.mem[200])
        `CHK("rm mark", 6'h2A, ioc_unit_model_inst.mem[201])
    endtask
    task automatic t_write_num(logic [7:0] u, int n);
        ioc_unit_model_inst.mem[300] = 6'h33;
        ioc_unit_model_inst.mem[301] = 6'h25;
        ioc_unit_model_inst.mem[302] = 6'h2A;
        run(write_numeric_instr, 16'h012C, u);
        wait_done();
        `CHK("count", n, ioc_unit_model_inst.got.size())
        `CHK("flag", 1'b1, ioc_unit_model_inst.got[0][8])
        `CHK("digit", 4'h5, ioc_unit_model_inst.got[1][3:0])
        `CHK("kept", 6'h33, ioc_unit_model_inst.mem[300])
        if (n == 3) `CHK("eol", 1'b1, ioc_unit_model_inst.got[2][10])
    endtask
    task automatic t_write_alpha();
        ioc_unit_model_inst.mem[500] = 6'h14;
        ioc_unit_model_inst.mem[501] = 6'h11;
        ioc_unit_model_inst.mem[503] = 6'h2A;
        run(write_alpha_instr, 16'h01F5, 8'h02);
        wait_done();
        `CHK("a count", 2, ioc_unit_model_inst.got.size())
        `CHK("a char", 11'h241, ioc_unit_model_inst.got[0])
        `CHK("a eol", 1'b1, ioc_unit_model_inst.got[1][10])
        `CHK("a susp", 1'b0, suspended)
    endtask
    task automatic t_suspend();
        ioc_unit_model_inst.mem[601] = 6'h2A;
        run(write_alpha_instr, 16'h0259, 8'h01);
        wait_done();
        `CHK("susp", 1'b1, suspended)
        `CHK("s count", 0, ioc_unit_model_inst.got.size())
    endtask
    task automatic t_dump(logic [7:0] u, logic [15:0] p, int n);
        ioc_unit_model_inst.mem[19990] = 6'h30;
        ioc_unit_model_inst.mem[19995] = 6'h2A;
        run(dump_numeric_instr, p, u);
        wait_done();
        `CHK("d count", n, ioc_unit_model_inst.got.size())
        if (u == 8'h02) `CHK("d eol", 1'b1, ioc_unit_model_inst.got[n-1][10])
        if (u == 8'h04) `CHK("d fzero", 4'hF, ioc_unit_model_inst.got[0][7:4])
        if (u == 8'h09)
            `CHK("d mark", 4'hA, ioc_unit_model_inst.got[11][3:0])
    endtask

    initial begin
        srst = 1'b1; start = 1'b0; op = read_numeric_instr;
        p_addr = 16'h0000; unit_code = 8'h00; release_key = 1'b0;
        in_valid = 1'b0; in_data = 10'h000;
        repeat (4) @(posedge core_clk);
        #2 srst = 1'b0;
        `CHK("idle", 1'b0, busy)
        t_read_tape();
        t_lone_mark();
        t_read_num();
        t_write_num(8'h01, 2);
        t_write_num(8'h02, 3);
        t_write_alpha();
        t_suspend();
        t_dump(8'h02, 16'h4E1B, 6);
        t_dump(8'h04, 16'h4E16, 80);
        t_dump(8'h09, 16'h4E10, 197);
        finish_test();
    end
endmodule
